// *** logic/blink_gen.sv ***
`timescale 1ns/10ps
`default_nettype none

module blink_gen #(
    parameter int unsigned HALF_CYCLES = 2
) (
    input  wire logic clk,      // System clock
    input  wire logic rst_n,    // Asynchronous reset, active low
    blink_if.gen      bus       // Run request in, pattern level out
);

    localparam int unsigned CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;

    typedef struct packed {
        logic [CW-1:0] count;
        logic          level;
    } blink_state_s;

    blink_state_s cur;
    blink_state_s next_cur;

    // Equal on and off halves; the pattern restarts lit so a blink is never missed.
    always_comb begin
        next_cur = cur;
        if (!bus.run) begin
            next_cur.count = '0;
            next_cur.level = 1'b1;
        end else if (cur.count == CW'(HALF_CYCLES - 1)) begin
            next_cur.count = '0;
            next_cur.level = ~cur.level;
        end else begin
            next_cur.count = cur.count + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '{count: '0, level: 1'b1};
        end else begin
            cur <= next_cur;
        end
    end

    assign bus.level = cur.level;

endmodule : blink_gen

`default_nettype wire

// *** logic/blink_if.sv ***
`timescale 1ns/10ps
`default_nettype none

interface blink_if;
    logic run;
    logic level;
    modport gen  (input run, output level);
    modport user (output run, input level);
endinterface : blink_if

`default_nettype wire

// *** logic/card_mon_cfg.svh ***
`ifndef CARD_MON_CFG_SVH
`define CARD_MON_CFG_SVH

// System clock rate and blink periods.
`define CLK_HZ              25000000
`define SLOW_PERIOD_MS      1000
`define FAST_PERIOD_MS      100

// APB register byte offsets.
`define OFF_FLAGS           8'h00
`define OFF_IRQ_STATUS      8'h04
`define OFF_IRQ_ENABLE      8'h08
`define OFF_IRQ_CLEAR       8'h0C
`define OFF_STATE           8'h10

// Field positions in the flag register.
`define BIT_USABLE          0
`define BIT_ACTIVE          1
`define BIT_STOP            2

// Event positions in the interrupt registers.
`define EV_READY            0
`define EV_GONE             1
`define EV_XFER_DONE        2
`define EV_STOPPED          3
`define EV_MAINT_REJECT     4
`define NUM_EVENTS          5

// Reset values.
`define RST_STOP            1'b0
`define RST_IRQ_ENABLE      5'h00
`define RST_IRQ_STATUS      5'h00

`endif

// *** logic/card_mon_pkg.sv ***
`include "card_mon_cfg.svh"

package card_mon_pkg;

    typedef enum logic [2:0] {
        ST_NO_CARD,
        ST_IDENT,
        ST_IDLE,
        ST_XFER,
        ST_STOPPING,
        ST_STOPPED,
        ST_BAD
    } card_state_e;

    typedef struct packed {
        card_state_e                 state;
        logic                        stop_flag;
        logic                        stop_prev;
        logic                        present_prev;
        logic [`NUM_EVENTS-1:0]      irq_status;
        logic [`NUM_EVENTS-1:0]      irq_enable;
        logic [31:0]                 rdata;
        logic                        slverr;
        logic                        led;
        logic                        maint_accept;
        logic                        maint_reject;
    } mon_state_s;

    typedef struct packed {
        logic [2:0]                  ff;
        logic                        out;
    } sync_state_s;

endpackage : card_mon_pkg

// *** logic/pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module pin_sync
    import card_mon_pkg::*;
(
    input  wire logic clk,      // System clock
    input  wire logic rst_n,    // Asynchronous reset, active low
    input  wire logic pin,      // Raw pin level
    output logic      level     // Filtered level
);

    sync_state_s cur;
    sync_state_s next_cur;

    // Stage 0 feeds only stage 1; the output moves when stages 1 and 2 agree.
    always_comb begin
        next_cur    = cur;
        next_cur.ff = {cur.ff[1:0], pin};
        if (cur.ff[1] == cur.ff[2]) begin
            next_cur.out = cur.ff[2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign level = cur.out;

endmodule : pin_sync

`default_nettype wire

// *** logic/sd_card_status_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none

module sd_card_status_monitor
    import card_mon_pkg::*;
#(
    parameter int unsigned SLOW_HALF_CYCLES = ((`SLOW_PERIOD_MS) * (`CLK_HZ / 1000)) / 2,
    parameter int unsigned FAST_HALF_CYCLES = ((`FAST_PERIOD_MS) * (`CLK_HZ / 1000)) / 2
) (
    input  wire logic        pclk,             // APB and system clock
    input  wire logic        presetn,          // Asynchronous reset, active low
    input  wire logic        psel,             // APB select
    input  wire logic        penable,          // APB access phase
    input  wire logic        pwrite,           // APB direction, high for write
    input  wire logic [7:0]  paddr,            // APB byte address
    input  wire logic [31:0] pwdata,           // APB write data
    output logic      [31:0] prdata,           // APB read data
    output logic             pready,           // APB ready
    output logic             pslverr,          // APB error on unmapped address
    input  wire logic        card_detect_pin,  // Slot detect pin, high when inserted
    input  wire logic        card_ident_ok,    // Pulse, card identified and supported
    input  wire logic        card_ident_fail,  // Pulse, card unsupported or unformatted
    input  wire logic        xfer_req,         // Level, user logic wants a transfer
    input  wire logic        xfer_done,        // Pulse, current transfer finished
    output logic             access_grant,     // Level, transfer may proceed
    input  wire logic        maint_req,        // Pulse, host maintenance file operation
    input  wire logic        ctrl_running,     // Level, controller is in run state
    output logic             maint_accept,     // Pulse, maintenance operation accepted
    output logic             maint_reject,     // Pulse, maintenance operation refused
    output logic             status_led,       // Card status indicator, high is lit
    output logic             irq               // Level interrupt
);

    ////////////////////////////////////////////////////////////////////////////

    logic       card_present;
    blink_if    slow_bus ();
    blink_if    fast_bus ();

    pin_sync u_detect_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .pin   (card_detect_pin),
        .level (card_present)
    );

    blink_gen #(
        .HALF_CYCLES (SLOW_HALF_CYCLES)
    ) u_slow_blink (
        .clk   (pclk),
        .rst_n (presetn),
        .bus   (slow_bus.gen)
    );

    blink_gen #(
        .HALF_CYCLES (FAST_HALF_CYCLES)
    ) u_fast_blink (
        .clk   (pclk),
        .rst_n (presetn),
        .bus   (fast_bus.gen)
    );

    ////////////////////////////////////////////////////////////////////////////

    mon_state_s cur;
    mon_state_s next_cur;

    logic                   setup_phase;
    logic                   access_phase;
    logic                   stop_rise;
    logic                   card_gone;
    logic [`NUM_EVENTS-1:0] events;
    logic [`NUM_EVENTS-1:0] irq_clear;
    logic                   usable;
    logic                   active;

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;

    // A level that stays high does nothing; only the transition stops access.
    assign stop_rise = cur.stop_flag & ~cur.stop_prev;

    assign card_gone = cur.present_prev & ~card_present;

    // Ready for use only in idle or during a transfer.
    assign usable = (cur.state == ST_IDLE) || (cur.state == ST_XFER);

    // A transfer that was running when the stop arrived is still an access.
    assign active = (cur.state == ST_XFER) || (cur.state == ST_STOPPING);

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_cur = cur;
        events = '0;
        irq_clear = '0;
        next_cur.stop_prev = cur.stop_flag;
        next_cur.present_prev = card_present;
        next_cur.maint_accept = 1'b0;
        next_cur.maint_reject = 1'b0;

        if (card_gone) begin
            events[`EV_GONE] = 1'b1;
        end

        case (cur.state)
            ST_NO_CARD: begin
                if (card_present) begin
                    next_cur.state = ST_IDENT;
                end
            end
            ST_IDENT: begin
                if (!card_present) begin
                    next_cur.state = ST_NO_CARD;
                end else if (stop_rise) begin
                    next_cur.state = ST_STOPPED;
                    events[`EV_STOPPED] = 1'b1;
                end else if (card_ident_fail) begin
                    next_cur.state = ST_BAD;
                end else if (card_ident_ok) begin
                    next_cur.state = ST_IDLE;
                    events[`EV_READY] = 1'b1;
                end
            end
            ST_IDLE: begin
                if (!card_present) begin
                    next_cur.state = ST_NO_CARD;
                end else if (stop_rise) begin
                    // Nothing in flight, so the stop completes at once.
                    next_cur.state = ST_STOPPED;
                    events[`EV_STOPPED] = 1'b1;
                end else if (xfer_req) begin
                    next_cur.state = ST_XFER;
                end
            end
            ST_XFER: begin
                if (!card_present) begin
                    next_cur.state = ST_NO_CARD;
                end else if (stop_rise && !xfer_done) begin
                    // The running transfer may end cleanly; none follows it.
                    next_cur.state = ST_STOPPING;
                end else if (stop_rise) begin
                    next_cur.state = ST_STOPPED;
                    events[`EV_STOPPED] = 1'b1;
                    events[`EV_XFER_DONE] = 1'b1;
                end else if (xfer_done) begin
                    next_cur.state = ST_IDLE;
                    events[`EV_XFER_DONE] = 1'b1;
                end
            end
            ST_STOPPING: begin
                if (!card_present) begin
                    next_cur.state = ST_NO_CARD;
                end else if (xfer_done) begin
                    next_cur.state = ST_STOPPED;
                    events[`EV_STOPPED] = 1'b1;
                    events[`EV_XFER_DONE] = 1'b1;
                end
            end
            ST_STOPPED: begin
                // Only a removal leads out; reinsertion starts identification anew.
                if (!card_present) begin
                    next_cur.state = ST_NO_CARD;
                end
            end
            ST_BAD: begin
                if (!card_present) begin
                    next_cur.state = ST_NO_CARD;
                end
            end
            default: begin
                next_cur.state = ST_NO_CARD;
            end
        endcase

        // Indicator pattern follows the state; registered to keep the pin glitch free.
        case (cur.state)
            ST_IDLE:     next_cur.led = 1'b1;
            ST_IDENT:    next_cur.led = slow_bus.level;
            ST_STOPPING: next_cur.led = slow_bus.level;
            ST_XFER:     next_cur.led = fast_bus.level;
            default:     next_cur.led = 1'b0;
        endcase

        // Host maintenance requests.
        if (maint_req) begin
            if (!card_present || ctrl_running) begin
                next_cur.maint_reject = 1'b1;
                events[`EV_MAINT_REJECT] = 1'b1;
            end else begin
                next_cur.maint_accept = 1'b1;
            end
        end

        // APB read data and error are prepared in the setup phase.
        if (setup_phase) begin
            next_cur.slverr = 1'b0;
            next_cur.rdata = '0;
            case (paddr)
                `OFF_FLAGS: begin
                    next_cur.rdata[`BIT_USABLE] = usable;
                    next_cur.rdata[`BIT_ACTIVE] = active;
                    next_cur.rdata[`BIT_STOP] = cur.stop_flag;
                end
                `OFF_IRQ_STATUS: begin
                    next_cur.rdata[`NUM_EVENTS-1:0] = cur.irq_status;
                end
                `OFF_IRQ_ENABLE: begin
                    next_cur.rdata[`NUM_EVENTS-1:0] = cur.irq_enable;
                end
                `OFF_IRQ_CLEAR: begin
                    next_cur.rdata = '0;
                end
                `OFF_STATE: begin
                    next_cur.rdata[3:0] = {cur.led, cur.state};
                end
                default: begin
                    next_cur.slverr = 1'b1;
                end
            endcase
        end

        // Writes take effect at the access edge; the usable and active bits ignore them.
        if (access_phase && pwrite && !cur.slverr) begin
            case (paddr)
                `OFF_FLAGS: begin
                    next_cur.stop_flag = pwdata[`BIT_STOP];
                end
                `OFF_IRQ_ENABLE: begin
                    next_cur.irq_enable = pwdata[`NUM_EVENTS-1:0];
                end
                `OFF_IRQ_CLEAR: begin
                    irq_clear = pwdata[`NUM_EVENTS-1:0];
                end
                default: begin
                    irq_clear = '0;
                end
            endcase
        end

        // A new event in the cycle of its clear stays set.
        next_cur.irq_status = (cur.irq_status & ~irq_clear) | events;
    end

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur.state        <= ST_NO_CARD;
            cur.stop_flag    <= `RST_STOP;
            cur.stop_prev    <= `RST_STOP;
            cur.present_prev <= 1'b0;
            cur.irq_status   <= `RST_IRQ_STATUS;
            cur.irq_enable   <= `RST_IRQ_ENABLE;
            cur.rdata        <= '0;
            cur.slverr       <= 1'b0;
            cur.led          <= 1'b0;
            cur.maint_accept <= 1'b0;
            cur.maint_reject <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign slow_bus.run = (cur.state == ST_IDENT) || (cur.state == ST_STOPPING);
    assign fast_bus.run = (cur.state == ST_XFER);

    // Grant drops the cycle the stop lands, so no new transfer can slip in.
    assign access_grant = (cur.state == ST_XFER) && !stop_rise;

    assign prdata       = cur.rdata;
    assign pready       = 1'b1;
    assign pslverr      = cur.slverr;
    assign maint_accept = cur.maint_accept;
    assign maint_reject = cur.maint_reject;
    assign status_led   = cur.led;
    assign irq          = |(cur.irq_status & cur.irq_enable);

endmodule : sd_card_status_monitor

`default_nettype wire

// *** tb/card_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module card_model (
    input  wire logic       pclk,            // Clock
    input  wire logic       present,         // Card in slot
    input  wire logic       good,            // Card supported
    input  wire logic       access_grant,    // Transfer allowed
    input  wire logic [7:0] ident_dly,       // Identify delay
    input  wire logic [7:0] xfer_len,        // Transfer length
    output logic            card_detect_pin, // Slot detect
    output var logic        card_ident_ok,   // Identify passed
    output var logic        card_ident_fail, // Identify failed
    output var logic        xfer_done        // Transfer finished
);
    logic       was = 1'b0;
    logic       busy = 1'b0;
    logic [8:0] icnt = 9'h000;
    logic [7:0] xcnt = 8'h00;

    initial card_ident_ok = 1'b0;
    initial card_ident_fail = 1'b0;
    initial xfer_done = 1'b0;

    // The bench moves the card only while the indicator is steady or dark.
    assign card_detect_pin = present;

    // A started transfer runs to its end even if the grant drops, as a real card does.
    always @(posedge pclk) begin
        was <= present;
        card_ident_ok <= 1'b0;
        card_ident_fail <= 1'b0;
        xfer_done <= 1'b0;
        if (present && !was) begin
            icnt <= {1'b0, ident_dly} + 9'h008;
        end else if (icnt != 9'h000) begin
            icnt <= icnt - 9'h001;
            card_ident_ok <= icnt == 9'h001 && good;
            card_ident_fail <= icnt == 9'h001 && !good;
        end
        if (!busy && access_grant && !xfer_done) begin
            busy <= 1'b1;
            xcnt <= xfer_len;
        end else if (busy && xcnt != 8'h00) begin
            xcnt <= xcnt - 8'h01;
        end else if (busy) begin
            busy <= 1'b0;
            xfer_done <= 1'b1;
        end
    end
endmodule : card_model

`default_nettype wire

// *** tb/sd_card_status_monitor_chk.sv ***
`timescale 1ns/10ps
`default_nettype none

module sd_card_status_monitor_chk #(
    parameter int unsigned FAST_HALF_CYCLES = 2
) (
    input wire logic pclk,            // Clock
    input wire logic presetn,         // Reset, active low
    input wire logic card_detect_pin, // Slot detect
    input wire logic xfer_req,        // Transfer wanted
    input wire logic xfer_done,       // Transfer finished
    input wire logic access_grant,    // Transfer allowed
    input wire logic maint_req,       // Maintenance request
    input wire logic ctrl_running,    // Controller runs
    input wire logic maint_accept,    // Maintenance taken
    input wire logic maint_reject,    // Maintenance refused
    input wire logic status_led       // Indicator
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Eight low samples cover the detect filter plus the indicator lag.
    chk_led_dark: assert property (!card_detect_pin [*8] |-> !status_led)
        else $error("indicator lit with no card");
    chk_nocard_grant: assert property (!card_detect_pin [*8] |-> !access_grant)
        else $error("grant with no card");
    chk_grant_drop: assert property (access_grant && xfer_done |=> !access_grant)
        else $error("grant outlived transfer");
    chk_grant_cause: assert property ($rose(access_grant) |-> $past(xfer_req))
        else $error("grant without request");
    chk_fast_blink: assert property (access_grant [*8] |->
        status_led != $past(status_led, FAST_HALF_CYCLES))
        else $error("indicator not fast blinking");
    chk_maint_nocard: assert property (!card_detect_pin [*8] ##0 maint_req |=>
        maint_reject && !maint_accept) else $error("maintenance taken with no card");
    chk_maint_run: assert property (maint_req && ctrl_running |=>
        maint_reject && !maint_accept) else $error("maintenance taken while running");
    chk_maint_cause: assert property (maint_accept |->
        $past(maint_req) && !$past(ctrl_running)) else $error("accept without cause");

    cover property ($rose(access_grant));
    cover property (maint_accept);
    cover property (maint_reject);
endmodule : sd_card_status_monitor_chk

bind sd_card_status_monitor sd_card_status_monitor_chk #(
    .FAST_HALF_CYCLES(FAST_HALF_CYCLES)
) i_sd_card_status_monitor_chk (.pclk, .presetn, .card_detect_pin, .xfer_req, .xfer_done,
    .access_grant, .maint_req, .ctrl_running, .maint_accept, .maint_reject, .status_led);

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import card_mon_pkg::*;

    localparam int SLOW = 8;
    localparam int FAST = 2;

    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        xfer_req = 1'b0, maint_req = 1'b0, ctrl_running = 1'b0;
    logic        present = 1'b0, good = 1'b1, e;
    logic [7:0]  paddr = 8'h00, ident_dly = 8'h28, xfer_len = 8'h1E;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, card_detect_pin, card_ident_ok, card_ident_fail;
    logic        xfer_done, access_grant, maint_accept, maint_reject, status_led, irq;
    int          err_count = 0, num_checks = 0, cyc = 0, n;
    integer      seed = 32'hFE130360;

    sd_card_status_monitor #(.SLOW_HALF_CYCLES(SLOW), .FAST_HALF_CYCLES(FAST))
    i_sd_card_status_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .card_detect_pin, .card_ident_ok, .card_ident_fail,
        .xfer_req, .xfer_done, .access_grant, .maint_req, .ctrl_running, .maint_accept,
        .maint_reject, .status_led, .irq);
    card_model i_card_model (.pclk, .present, .good, .access_grant, .ident_dly, .xfer_len,
        .card_detect_pin, .card_ident_ok, .card_ident_fail, .xfer_done);

    always #20 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    ////////////////////////////////////////
    task automatic results;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask : rd

    // Reference flag word for a given card state and stop setting.
    function automatic logic [31:0] flg(input int st, input logic stop);
        return {29'h0, stop, st == 3 || st == 4, st == 2 || st == 3};
    endfunction : flg

    task automatic wait_st(input int st);
        for (n = 0; n < 100 && q[2:0] !== 3'(st); n++)
            apb(1'b0, 8'h10, 32'h0);
        chk("state", st, {29'h0, q[2:0]});
    endtask : wait_st

    // A window of one slow period holds half a period lit for either blink rate.
    task automatic leds(input int x, input string nm);
        int c;
        c = 0;
        repeat (2 * SLOW) @(negedge pclk) c += int'(status_led === 1'b1);
        @(posedge pclk);
        chk(nm, x, c);
    endtask : leds

    task automatic maint(input logic run, input logic rej);
        @(posedge pclk);
        ctrl_running <= run;
        maint_req <= 1'b1;
        @(posedge pclk);
        maint_req <= 1'b0;
        @(negedge pclk);
        chk("accept", !rej, maint_accept);
        chk("reject", rej, maint_reject);
        @(posedge pclk);
    endtask : maint

    task automatic grant_wait(input logic [7:0] len);
        @(posedge pclk);
        xfer_len <= len;
        xfer_req <= 1'b1;
        for (n = 0; n < 50 && access_grant !== 1'b1; n++) @(posedge pclk);
        xfer_req <= 1'b0;
        chk("grant", 1, access_grant);
    endtask : grant_wait

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h0, "flags");
        rd(8'h08, 32'h0, "enable");
        apb(1'b1, 8'h00, 32'h3);
        rd(8'h00, 32'h0, "flags_ro");
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 1, e);
        present <= 1'b1;
        wait_st(1);
        leds(SLOW, "slow_ident");
        wait_st(2);
        leds(2 * SLOW, "steady");
        rd(8'h00, flg(2, 1'b0), "usable");
        chk("irq_masked", 0, irq);
        rd(8'h04, 32'h1, "ready_ev");
        apb(1'b1, 8'h08, 32'h1F);
        @(negedge pclk) chk("irq_on", 1, irq);
        apb(1'b1, 8'h0C, 32'h1F);
        @(negedge pclk) chk("irq_off", 0, irq);
        grant_wait(8'h1E);
        rd(8'h00, flg(3, 1'b0), "active");
        leds(SLOW, "fast");
        wait_st(2);
        rd(8'h00, flg(2, 1'b0), "done");
        rd(8'h04, 32'h4, "done_ev");
        repeat (6) begin
            e = 1'($random(seed));
            maint(e, e);
        end
        grant_wait(8'h3C);
        apb(1'b1, 8'h00, 32'h4);
        // Bit 3 holds the indicator, which is mid-blink here, so only the state field counts.
        apb(1'b0, 8'h10, 32'h0);
        chk("stopping", 32'h4, {29'h0, q[2:0]});
        chk("grant_off", 0, access_grant);
        rd(8'h00, flg(4, 1'b1), "stop_flags");
        leds(SLOW, "slow_stop");
        wait_st(5);
        leds(0, "dark_stop");
        xfer_req <= 1'b1;
        apb(1'b1, 8'h00, 32'h4);
        rd(8'h10, 32'h5, "refused");
        xfer_req <= 1'b0;
        rd(8'h00, flg(5, 1'b1), "stopped");
        present <= 1'b0;
        wait_st(0);
        leds(0, "dark_empty");
        maint(1'b0, 1'b1);
        ident_dly <= 8'($random(seed)) & 8'h1F;
        present <= 1'b1;
        wait_st(2);
        present <= 1'b0;
        wait_st(0);
        good <= 1'b0;
        present <= 1'b1;
        wait_st(6);
        leds(0, "dark_bad");
        rd(8'h00, flg(6, 1'b1), "bad");
        rd(8'h04, 32'h1F, "events");
        results();
    end
endmodule : tb_top

`default_nettype wire
